// ===== ssts_top.sv
// servo start acceptance, position status, torque limit selection and encoder outputs
// What this block does
// - encoder B lags A by quarter cycle
// - one index pulse per motor revolution
// - index active low at zero point
// - index pulse at least 400 us wide
// - start ignored before main power established
// - move launches only on start rising edge
// - start to move latency under 3 ms
// - no new start during positioning
// - status flags assert after stop then servo-on
// - move done from command, in-position range, servo-on
// - coarse match from command range, servo-on
// - settled from feedback versus in-position range
// - torque clamped to forward and reverse limits
// - selection picks smaller alternate limit
// - indexer mode enables alternate limit automatically
// - limiting flag when torque reaches limit
// - ready once operable after servo-on
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module ssts_top #(
	parameter int unsigned INDEX_CYC = ssts_pkg::INDEX_MIN_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins from outside the clock domain
	input wire logic startCommandBit,
	input wire logic mainPowerOk,
	input wire logic forcedStopIn,
	input wire logic alarmIn,
	// motor side, same clock
	input wire logic fbStep,
	input wire logic fbDir,
	input wire logic signed [15:0] torqueCmd,
	output logic cmdStepOut,
	output logic cmdDirOut,
	output logic signed [15:0] torqueOut,
	// status outputs
	output logic readyOut,
	output logic moveDoneOut,
	output logic coarseMatchOut,
	output logic settledOut,
	output logic torqueLimitingOut,
	// encoder outputs
	output logic encQuadAOut,
	output logic encQuadAInv,
	output logic encQuadBOut,
	output logic encQuadBInv,
	output logic encIndexOut,
	output logic encIndexInv
);
	localparam logic [15:0] STEP_LAST = 16'(ssts_pkg::CMD_STEP_CYC - 1);

	ssts_pkg::ssts_ctrl_type ctrl_q;
	ssts_pkg::ssts_status_type status;
	logic [15:0] inPosRange_q;
	logic [15:0] coarseRange_q;
	logic [15:0] fwdLimit_q;
	logic [15:0] revLimit_q;
	logic [15:0] altLimit_q;
	logic [31:0] moveDist_q;

	logic [3:0] pinSync;
	logic startSync;
	logic powerSync;
	logic stopSync;
	logic alarmSync;
	logic startPrev_q;
	logic startRise;
	logic startAccept;
	logic stopCond;
	logic ready_q;

	logic signed [31:0] cmdPos_q;
	logic signed [31:0] target_q;
	logic signed [31:0] fbPos_q;
	logic busy_q;
	logic [15:0] stepCnt_q;
	logic [32:0] remain;
	logic [32:0] droop;

	logic altActive;
	logic [15:0] fwdEff;
	logic [15:0] revEff;
	logic [16:0] torqueMag;
	logic [16:0] limitEff;

	logic awHeld_q;
	logic wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite;
	logic wrHit;
	logic rdHit;
	logic [31:0] rdMux;

	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [32:0] absDiff(input logic signed [31:0] a,
			input logic signed [31:0] b);
		logic signed [32:0] d;
		d = 33'(a) - 33'(b);
		return d[32] ? 33'(-d) : 33'(d);
	endfunction

	// pin synchronisers
	// start through two flops
	ssts_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({startCommandBit, mainPowerOk, forcedStopIn, alarmIn}),
		.q(pinSync)
	);

	assign {startSync, powerSync, stopSync, alarmSync} = pinSync;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			startPrev_q <= 1'b0;
		end else begin
			startPrev_q <= startSync;
		end
	end

	assign startRise = startSync & ~startPrev_q;
	assign stopCond = ~ctrl_q.servoOn | alarmSync | stopSync | ~powerSync;
	assign startAccept = startRise & ready_q & powerSync & ~busy_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= ~stopCond;
		end
	end

	// feedback position counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fbPos_q <= '0;
		end else if (fbStep) begin
			fbPos_q <= fbDir ? 32'(fbPos_q - 1) : 32'(fbPos_q + 1);
		end
	end

	// internal position command generator
	// move begins the cycle after acceptance
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmdPos_q <= '0;
			target_q <= '0;
			busy_q <= 1'b0;
			stepCnt_q <= '0;
			cmdStepOut <= 1'b0;
			cmdDirOut <= 1'b0;
		end else begin
			cmdStepOut <= 1'b0;
			if (stopCond) begin
				// command collapses to feedback so flags rise on resume
				cmdPos_q <= fbPos_q;
				target_q <= fbPos_q;
				busy_q <= 1'b0;
				stepCnt_q <= '0;
			end else if (startAccept) begin
				target_q <= 32'(cmdPos_q + $signed(moveDist_q));
				busy_q <= 1'b1;
				stepCnt_q <= '0;
			end else if (busy_q) begin
				if (cmdPos_q == target_q) begin
					busy_q <= 1'b0;
				end else if (stepCnt_q == STEP_LAST) begin
					stepCnt_q <= '0;
					cmdStepOut <= 1'b1;
					cmdDirOut <= (target_q < cmdPos_q);
					cmdPos_q <= (target_q < cmdPos_q) ? 32'(cmdPos_q - 1) : 32'(cmdPos_q + 1);
				end else begin
					stepCnt_q <= 16'(stepCnt_q + 16'h0001);
				end
			end
		end
	end

	assign remain = absDiff(target_q, cmdPos_q);
	assign droop = absDiff(cmdPos_q, fbPos_q);

	// status flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			moveDoneOut <= 1'b0;
			coarseMatchOut <= 1'b0;
			settledOut <= 1'b0;
		end else begin
			moveDoneOut <= ctrl_q.servoOn & ~stopCond & ~busy_q & (droop <= 33'(inPosRange_q));
			coarseMatchOut <= ctrl_q.servoOn & ~stopCond & (remain <= 33'(coarseRange_q));
			settledOut <= ctrl_q.servoOn & ~stopCond & (droop <= 33'(inPosRange_q));
		end
	end

	// indexer mode uses alternate limit while holding
	assign altActive = ctrl_q.indexerMode ? ~busy_q : ctrl_q.torqueLimitSelect;
	assign fwdEff = (altActive && altLimit_q < fwdLimit_q) ? altLimit_q : fwdLimit_q;
	assign revEff = (altActive && altLimit_q < revLimit_q) ? altLimit_q : revLimit_q;
	assign torqueMag = torqueCmd[15] ? 17'(-(17'(torqueCmd))) : 17'(torqueCmd);
	assign limitEff = torqueCmd[15] ? 17'(revEff) : 17'(fwdEff);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			torqueOut <= '0;
			torqueLimitingOut <= 1'b0;
		end else if (stopCond) begin
			torqueOut <= '0;
			torqueLimitingOut <= 1'b0;
		end else if (torqueMag >= limitEff) begin
			torqueOut <= torqueCmd[15] ? 16'(-(17'(limitEff))) : 16'(limitEff);
			torqueLimitingOut <= 1'b1;
		end else begin
			torqueOut <= torqueCmd;
			torqueLimitingOut <= 1'b0;
		end
	end

	assign readyOut = ready_q;

	ssts_enc_out #(
		.CPR(ssts_pkg::COUNTS_PER_REV),
		.INDEX_CYC(INDEX_CYC)
	) u_enc (
		.clk(clk),
		.arst_n(arst_n),
		.fbStep(fbStep),
		.fbDir(fbDir),
		.encQuadAOut(encQuadAOut),
		.encQuadAInv(encQuadAInv),
		.encQuadBOut(encQuadBOut),
		.encQuadBInv(encQuadBInv),
		.encIndexOut(encIndexOut),
		.encIndexInv(encIndexInv)
	);

	// axi4-lite write side: address and data caught in either order
	assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
	assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
	assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_q <= 1'b0;
			awAddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wHeld_q <= 1'b0;
			wData_q <= '0;
			wStrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_q <= 1'b1;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
		end
	end

	always_comb begin
		unique case (awAddr_q)
			ssts_pkg::ADDR_CTRL, ssts_pkg::ADDR_STATUS, ssts_pkg::ADDR_INPOS_RANGE,
			ssts_pkg::ADDR_COARSE_RANGE, ssts_pkg::ADDR_FWD_LIMIT, ssts_pkg::ADDR_REV_LIMIT,
			ssts_pkg::ADDR_ALT_LIMIT, ssts_pkg::ADDR_MOVE_DIST, ssts_pkg::ADDR_CMD_POS,
			ssts_pkg::ADDR_FB_POS: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ssts_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrHit ? ssts_pkg::RESP_OKAY : ssts_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// writable registers; status and positions ignore writes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= '0;
			inPosRange_q <= ssts_pkg::INPOS_RANGE_RST;
			coarseRange_q <= ssts_pkg::COARSE_RANGE_RST;
			fwdLimit_q <= ssts_pkg::LIMIT_RST;
			revLimit_q <= ssts_pkg::LIMIT_RST;
			altLimit_q <= ssts_pkg::LIMIT_RST;
			moveDist_q <= ssts_pkg::MOVE_DIST_RST;
		end else if (doWrite) begin
			unique case (awAddr_q)
				ssts_pkg::ADDR_CTRL: begin
					ctrl_q <= ssts_pkg::CTRL_W'(mergeStrb(32'(ctrl_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_INPOS_RANGE: begin
					inPosRange_q <= 16'(mergeStrb(32'(inPosRange_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_COARSE_RANGE: begin
					coarseRange_q <= 16'(mergeStrb(32'(coarseRange_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_FWD_LIMIT: begin
					fwdLimit_q <= 16'(mergeStrb(32'(fwdLimit_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_REV_LIMIT: begin
					revLimit_q <= 16'(mergeStrb(32'(revLimit_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_ALT_LIMIT: begin
					altLimit_q <= 16'(mergeStrb(32'(altLimit_q), wData_q, wStrb_q));
				end
				ssts_pkg::ADDR_MOVE_DIST: begin
					moveDist_q <= mergeStrb(moveDist_q, wData_q, wStrb_q);
				end
				default: begin
				end
			endcase
		end
	end

	// axi4-lite read side
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		status.mainPowerOk = powerSync;
		status.torqueLimiting = torqueLimitingOut;
		status.settled = settledOut;
		status.coarseMatch = coarseMatchOut;
		status.moveDone = moveDoneOut;
		status.busy = busy_q;
		status.ready = ready_q;
		rdHit = 1'b1;
		unique case (s_axi_araddr)
			ssts_pkg::ADDR_CTRL: rdMux = 32'(ctrl_q);
			ssts_pkg::ADDR_STATUS: rdMux = 32'(status);
			ssts_pkg::ADDR_INPOS_RANGE: rdMux = 32'(inPosRange_q);
			ssts_pkg::ADDR_COARSE_RANGE: rdMux = 32'(coarseRange_q);
			ssts_pkg::ADDR_FWD_LIMIT: rdMux = 32'(fwdLimit_q);
			ssts_pkg::ADDR_REV_LIMIT: rdMux = 32'(revLimit_q);
			ssts_pkg::ADDR_ALT_LIMIT: rdMux = 32'(altLimit_q);
			ssts_pkg::ADDR_MOVE_DIST: rdMux = moveDist_q;
			ssts_pkg::ADDR_CMD_POS: rdMux = cmdPos_q;
			ssts_pkg::ADDR_FB_POS: rdMux = fbPos_q;
			default: begin
				rdMux = '0;
				rdHit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ssts_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdHit ? ssts_pkg::RESP_OKAY : ssts_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== ssts_pkg.sv
// shared constants, register map and carrier types of the servo start/status/torque block
package ssts_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned INDEX_MIN_US = 400;
	localparam int unsigned INDEX_MIN_CYC = (INDEX_MIN_US * (CLK_HZ / 1000000));
	localparam int unsigned CMD_STEP_NS = 1000;
	localparam int unsigned CMD_STEP_CYC = (CMD_STEP_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned START_LATENCY_MAX_MS = 3;
	localparam int unsigned COUNTS_PER_REV = 4096;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INPOS_RANGE = 8'h08;
	localparam logic [7:0] ADDR_COARSE_RANGE = 8'h0c;
	localparam logic [7:0] ADDR_FWD_LIMIT = 8'h10;
	localparam logic [7:0] ADDR_REV_LIMIT = 8'h14;
	localparam logic [7:0] ADDR_ALT_LIMIT = 8'h18;
	localparam logic [7:0] ADDR_MOVE_DIST = 8'h1c;
	localparam logic [7:0] ADDR_CMD_POS = 8'h20;
	localparam logic [7:0] ADDR_FB_POS = 8'h24;

	// reset values
	localparam logic [15:0] INPOS_RANGE_RST = 16'h0064;
	localparam logic [15:0] COARSE_RANGE_RST = 16'h0000;
	localparam logic [15:0] LIMIT_RST = 16'h03e8;
	localparam logic [31:0] MOVE_DIST_RST = 32'h0000_0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// control register, bits 2..0
	typedef struct packed {
		logic indexerMode;
		logic torqueLimitSelect;
		logic servoOn;
	} ssts_ctrl_type;

	// status register, bits 6..0
	typedef struct packed {
		logic mainPowerOk;
		logic torqueLimiting;
		logic settled;
		logic coarseMatch;
		logic moveDone;
		logic busy;
		logic ready;
	} ssts_status_type;

	localparam int unsigned CTRL_W = $bits(ssts_ctrl_type);
	localparam int unsigned STATUS_W = $bits(ssts_status_type);
endpackage

// ===== ssts_sync.sv
// two-flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
module ssts_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ===== ssts_enc_out.sv
// encoder pulse outputs: quadrature pair and stretched index pulse
`timescale 1ns/1ns
module ssts_enc_out #(
	parameter int unsigned CPR = 4096,
	parameter int unsigned INDEX_CYC = 20000
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// feedback pulses
	input wire logic fbStep,
	input wire logic fbDir,
	// encoder outputs
	output logic encQuadAOut,
	output logic encQuadAInv,
	output logic encQuadBOut,
	output logic encQuadBInv,
	output logic encIndexOut,
	output logic encIndexInv
);
	localparam int unsigned RW = $clog2(CPR);
	localparam int unsigned CW = $clog2(INDEX_CYC + 1);
	localparam logic [RW-1:0] REV_LAST = RW'(CPR - 1);
	localparam logic [CW-1:0] IDX_LOAD = CW'(INDEX_CYC);

	logic [1:0] phase_d;
	logic [RW-1:0] revPos_q;
	logic [RW-1:0] revPos_d;
	logic [CW-1:0] idxCnt_q;

	always_comb begin
		phase_d = fbDir ? 2'(revPos_q[1:0] - 2'h1) : 2'(revPos_q[1:0] + 2'h1);
		if (fbDir) begin
			revPos_d = (revPos_q == '0) ? REV_LAST : RW'(revPos_q - 1'b1);
		end else begin
			revPos_d = (revPos_q == REV_LAST) ? '0 : RW'(revPos_q + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			revPos_q <= '0;
		end else if (fbStep) begin
			revPos_q <= revPos_d;
		end
	end

	// b lags a by a quarter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			encQuadAOut <= 1'b0;
			encQuadBOut <= 1'b1;
		end else if (fbStep) begin
			encQuadAOut <= phase_d[1];
			encQuadBOut <= ~(phase_d[1] ^ phase_d[0]);
		end
	end

	// index held at least 400 us
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idxCnt_q <= '0;
		end else if (fbStep && revPos_d == '0) begin
			idxCnt_q <= IDX_LOAD;
		end else if (idxCnt_q != '0) begin
			idxCnt_q <= CW'(idxCnt_q - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			encIndexOut <= 1'b1;
		end else begin
			encIndexOut <= ~(idxCnt_q != '0);
		end
	end

	assign encQuadAInv = ~encQuadAOut;
	assign encQuadBInv = ~encQuadBOut;
	assign encIndexInv = ~encIndexOut;
endmodule

// ===== ssts_host_model.sv
// host command device: gated start pulses on request
`timescale 1ns/1ns
module ssts_host_model #(
	parameter int unsigned HOLD_CYC = 120
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// requests from the bench, rude skips the gating
	input wire logic go,
	input wire logic rude,
	// device status
	input wire logic readyOut,
	input wire logic moveDoneOut,
	input wire logic coarseMatchOut,
	// start command
	output logic startCommandBit
);
	logic [15:0] holdCnt_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			startCommandBit <= 1'b0;
			holdCnt_q <= 16'h0000;
		end else if (holdCnt_q != 16'h0000) begin
			holdCnt_q <= holdCnt_q - 16'h0001;
			startCommandBit <= (holdCnt_q != 16'h0001);
		end else if (go && (rude || (readyOut && (moveDoneOut || coarseMatchOut)))) begin
			startCommandBit <= 1'b1;
			holdCnt_q <= 16'(HOLD_CYC);
		end
	end
endmodule

// ===== ssts_props.sv
// concurrent checks on the block's ports
`timescale 1ns/1ns
module ssts_props #(
	parameter int unsigned INDEX_CYC = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic startCommandBit,
	input wire logic mainPowerOk,
	input wire logic fbStep,
	input wire logic signed [15:0] torqueCmd,
	input wire logic cmdStepOut,
	input wire logic signed [15:0] torqueOut,
	input wire logic readyOut,
	input wire logic moveDoneOut,
	input wire logic coarseMatchOut,
	input wire logic settledOut,
	input wire logic torqueLimitingOut,
	input wire logic encQuadAOut,
	input wire logic encQuadBOut,
	input wire logic encIndexOut
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic [15:0] lowCnt_q;
	// cycles the index has been low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lowCnt_q <= 16'h0000;
		end else if (encIndexOut) begin
			lowCnt_q <= 16'h0000;
		end else begin
			lowCnt_q <= lowCnt_q + 16'h0001;
		end
	end
	AST_QUAD_GRAY: assert property (($changed(encQuadAOut) || $changed(encQuadBOut)) |->
		$past(fbStep) && !($changed(encQuadAOut) && $changed(encQuadBOut)))
		else $error("quadrature changed without a step or on both phases");
	AST_INDEX_AT_STEP: assert property ($fell(encIndexOut) |-> $past(fbStep, 2))
		else $error("index fell without a feedback step");
	AST_INDEX_WIDTH: assert property ($rose(encIndexOut) |-> lowCnt_q == 16'(INDEX_CYC))
		else $error("index pulse width wrong");
	AST_STEP_NEEDS_READY: assert property (cmdStepOut |-> readyOut || $past(readyOut))
		else $error("command step while not ready");
	AST_START_LATENCY: assert property ($rose(startCommandBit) && readyOut && mainPowerOk
		&& moveDoneOut |-> ##[45:60] cmdStepOut)
		else $error("accepted start gave no step in time");
	AST_STEP_NOT_DONE: assert property (cmdStepOut |-> !moveDoneOut)
		else $error("move done while commanding steps");
	AST_FLAGS_SERVO_ON: assert property ((moveDoneOut || coarseMatchOut || settledOut)
		|-> readyOut)
		else $error("position flag while servo off");
	AST_TORQUE_PASS: assert property ($past(readyOut) && readyOut && !torqueLimitingOut
		|-> torqueOut == $past(torqueCmd))
		else $error("unlimited torque not passed through");
	cover property ($fell(encIndexOut));
	cover property ($rose(torqueLimitingOut));
	cover property ($rose(moveDoneOut) && coarseMatchOut);
endmodule
bind ssts_top ssts_props #(.INDEX_CYC(INDEX_CYC)) uProps (.clk(clk), .arst_n(arst_n),
	.startCommandBit(startCommandBit), .mainPowerOk(mainPowerOk), .fbStep(fbStep),
	.torqueCmd(torqueCmd), .cmdStepOut(cmdStepOut), .torqueOut(torqueOut),
	.readyOut(readyOut), .moveDoneOut(moveDoneOut), .coarseMatchOut(coarseMatchOut),
	.settledOut(settledOut), .torqueLimitingOut(torqueLimitingOut),
	.encQuadAOut(encQuadAOut), .encQuadBOut(encQuadBOut), .encIndexOut(encIndexOut));

// ===== ssts_top_tb_top.sv
// self-checking bench for the servo start/status/torque block
`timescale 1ns/1ns
module ssts_top_tb_top;
	localparam int unsigned IDX_CYC = 20;
	logic clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, d, errCount = 0, nCompared = 0, expPos = 0;
	logic [31:0] idxFalls = 0, f0, abBad = 0, abRise = 0, r0;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] r, bresp, rresp;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid, startCommandBit, cmdStepOut, cmdDirOut;
	logic mainPowerOk = 1, forcedStopIn = 0, alarmIn = 0, fbStep = 0, fbDir = 0, manStep = 0;
	logic go = 0, rude = 0, idxPrev = 1, qa, qb, qai, qbi, idxOut, idxInv, ab0, qaPrev = 0;
	logic readyOut, moveDoneOut, coarseMatchOut, settledOut, torqueLimitingOut;
	logic signed [15:0] torqueCmd = 0, torqueOut;
	int i, k, t, seed = 32'h38254281;
	ssts_top #(.INDEX_CYC(IDX_CYC)) dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.startCommandBit(startCommandBit), .mainPowerOk(mainPowerOk),
		.forcedStopIn(forcedStopIn), .alarmIn(alarmIn), .fbStep(fbStep), .fbDir(fbDir),
		.torqueCmd(torqueCmd), .cmdStepOut(cmdStepOut), .cmdDirOut(cmdDirOut),
		.torqueOut(torqueOut), .readyOut(readyOut), .moveDoneOut(moveDoneOut),
		.coarseMatchOut(coarseMatchOut), .settledOut(settledOut),
		.torqueLimitingOut(torqueLimitingOut), .encQuadAOut(qa), .encQuadAInv(qai),
		.encQuadBOut(qb), .encQuadBInv(qbi), .encIndexOut(idxOut), .encIndexInv(idxInv));
	ssts_host_model host (.clk(clk), .arst_n(arst_n), .go(go), .rude(rude), .readyOut(readyOut),
		.moveDoneOut(moveDoneOut), .coarseMatchOut(coarseMatchOut),
		.startCommandBit(startCommandBit));
	initial begin
		forever #10 clk = ~clk;
	end
	// motor follows the command; manual steps for the encoder run
	always_ff @(posedge clk) begin
		fbStep <= cmdStepOut | manStep;
		fbDir <= manStep ? 1'b0 : cmdDirOut;
		idxPrev <= idxOut;
		if (idxPrev === 1'b1 && idxOut === 1'b0) idxFalls <= idxFalls + 1;
		qaPrev <= qa;
		// forward, a rises while b low
		if (qaPrev === 1'b0 && qa === 1'b1 && fbDir === 1'b0) begin
			if (qb === 1'b0) abRise <= abRise + 1;
			else abBad <= abBad + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errCount++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		@(posedge clk);
		ta = 0;
		tw = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awready) begin ta = 1; awvalid <= 0; end
			if (!tw && wready) begin tw = 1; wvalid <= 0; end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (!arready);
		arvalid <= 0;
		do @(posedge clk); while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic pulseGo(input logic rd);
		rude <= rd;
		go <= 1;
		@(posedge clk);
		go <= 0;
		rude <= 0;
	endtask
	// waits out one move; a rude start is thrown in at cycle rudeAt
	task automatic waitMove(input int rudeAt);
		for (k = 0; moveDoneOut && k < 100; k++) @(posedge clk);
		for (k = 0; !moveDoneOut && k < 1000; k++) begin
			go <= (k == rudeAt);
			rude <= (k == rudeAt);
			@(posedge clk);
		end
		go <= 0;
		rude <= 0;
		for (k = 0; startCommandBit && k < 300; k++) @(posedge clk);
	endtask
	function automatic logic [16:0] tqExp(input int c, input int a, input logic s);
		int lim;
		lim = (c >= 0) ? 300 : 200;
		if (s && a < lim) lim = a;
		if (c >= lim || c <= -lim) return {1'b1, 16'(c >= 0 ? lim : -lim)};
		return {1'b0, 16'(c)};
	endfunction
	task automatic tallyAndFinish;
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		errCount++;
		tallyAndFinish;
	end
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		axr(ssts_pkg::ADDR_INPOS_RANGE, d, r);
		chk("inposRange", d, 32'h0000_0064);
		axr(ssts_pkg::ADDR_ALT_LIMIT, d, r);
		chk("altLimit", d, 32'h0000_03e8);
		axr(8'h3c, d, r);
		chk("unmappedResp", {30'h0, r}, {30'h0, ssts_pkg::RESP_SLVERR});
		axw(ssts_pkg::ADDR_CTRL, 32'h0000_0001);
		repeat (6) @(posedge clk);
		chk("ready", {31'h0, readyOut}, 32'h1);
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 1 : (i == 1) ? -3 : 4 + ($random(seed) & 3);
			axw(ssts_pkg::ADDR_MOVE_DIST, d);
			expPos = expPos + d;
			pulseGo(0);
			waitMove((i < 2) ? -1 : 150);
			chk("cmdDir", {31'h0, cmdDirOut}, {31'h0, i == 1});
			axr(ssts_pkg::ADDR_CMD_POS, d, r);
			chk("cmdPos", d, expPos);
		end
		mainPowerOk <= 0;
		alarmIn <= 1;
		repeat (6) @(posedge clk);
		chk("readyOff", {31'h0, readyOut}, 32'h0);
		alarmIn <= 0;
		pulseGo(1);
		repeat (200) @(posedge clk);
		axr(ssts_pkg::ADDR_CMD_POS, d, r);
		chk("noPowerPos", d, expPos);
		mainPowerOk <= 1;
		repeat (6) @(posedge clk);
		axw(ssts_pkg::ADDR_MOVE_DIST, 32'h0000_0008);
		pulseGo(0);
		repeat (120) @(posedge clk);
		forcedStopIn <= 1;
		repeat (6) @(posedge clk);
		forcedStopIn <= 0;
		repeat (14) @(posedge clk);
		chk("resumeFlags", {29'h0, moveDoneOut, coarseMatchOut, settledOut}, 32'h7);
		axw(ssts_pkg::ADDR_FWD_LIMIT, 32'd300);
		axw(ssts_pkg::ADDR_REV_LIMIT, 32'd200);
		for (i = 0; i < 40; i++) begin
			if (i % 20 == 0) axw(ssts_pkg::ADDR_ALT_LIMIT, (i < 20) ? 32'd250 : 32'd300);
			d = $random(seed);
			axw(ssts_pkg::ADDR_CTRL, {29'h0, d[1:0], 1'b1});
			t = (i % 20 == 3) ? 300 : (i % 20 == 4) ? -200 : (i % 20 == 5) ? 249 :
				$random(seed) % 600;
			torqueCmd <= 16'(t);
			repeat (2) @(posedge clk);
			chk("torque", {15'h0, torqueLimitingOut, torqueOut},
				{15'h0, tqExp(t, (i < 20) ? 250 : 300, d[0] | d[1])});
		end
		torqueCmd <= 0;
		ab0 = qa ^ qb;
		f0 = idxFalls;
		r0 = abRise;
		for (i = 0; i < ssts_pkg::COUNTS_PER_REV; i++) begin
			manStep <= 1;
			@(posedge clk);
			manStep <= 0;
			repeat (7) @(posedge clk);
		end
		repeat (IDX_CYC + 5) @(posedge clk);
		chk("indexPerRev", idxFalls - f0, 32'h1);
		chk("quadPhase", {31'h0, qa ^ qb}, {31'h0, ab0});
		chk("quadRises", abRise - r0, ssts_pkg::COUNTS_PER_REV / 4);
		chk("quadLag", abBad, 32'h0);
		chk("encInv", {29'h0, qai, qbi, idxInv}, {29'h0, ~qa, ~qb, ~idxOut});
		tallyAndFinish;
	end
endmodule
